/* pkg/qps_pkg.sv */
// Constants, carriers and state layout of the quadrature position block.
// Assumes a 16-bit register port and one 200 MHz clock for everything.
package qps_pkg;

	// Clock rate of mclk in MHz.
	localparam int CLK_MHZ = 200;

	// Register indices on the 4-bit register address port.
	typedef logic [3:0] qps_addr_t;
	localparam qps_addr_t A_HCAP  = 4'h0;
	localparam qps_addr_t A_STAT  = 4'h1;
	localparam qps_addr_t A_POSL  = 4'h2;
	localparam qps_addr_t A_POSH  = 4'h3;
	localparam qps_addr_t A_POSHD = 4'h4;
	localparam qps_addr_t A_VELL  = 4'h5;
	localparam qps_addr_t A_VELH  = 4'h6;
	localparam qps_addr_t A_VELHD = 4'h7;
	localparam qps_addr_t A_CLR   = 4'h8;

	// Field positions in the capture control register (bit 0) and in the status and enable register.
	localparam int B_HCAP = 0;
	localparam int B_GE   = 13;
	localparam int B_LE   = 11;
	localparam int B_POV  = 9;
	localparam int B_HDN  = 7;
	localparam int B_VOV  = 5;
	localparam int B_HOM  = 3;
	localparam int B_IDX  = 1;

	// Flags sit on odd bits, their enables on the even bit below.
	localparam logic [15:0] M_FLAG = 16'h2aaa;
	localparam logic [15:0] M_EN   = 16'h1555;
	localparam logic [15:0] M_HCAP = 16'h0001;

	// Reset values, and the count step and top value used by the counters.
	localparam logic [15:0] R16 = 16'h0000;
	localparam logic [31:0] R32 = 32'h0000_0000;
	localparam logic [31:0] ONE32 = 32'h0000_0001;
	localparam logic [31:0] MAX32 = 32'hffff_ffff;

	// Position initialization modes that use the homing sequence.
	localparam logic [2:0] PI_FIRST  = 3'h3;
	localparam logic [2:0] PI_SECOND = 3'h4;

	// Homing sequence progress.
	typedef enum logic [1:0] {HM_IDLE, HM_ARMED, HM_ONE} qps_hm_t;

	// Register port request.
	typedef struct packed {
		logic [3:0]  addr;
		logic [15:0] wdata;
		logic        wr;
		logic        rd;
	} qps_bus_t;

	// Encoder pins after the two-stage synchronizers.
	typedef struct packed {
		logic a;
		logic b;
		logic idx;
		logic home;
	} qps_pins_t;

	// Whole state of the block.
	typedef struct packed {
		qps_pins_t   s1;
		qps_pins_t   s2;
		qps_pins_t   prev;
		logic        hcap;
		logic [15:0] stat;
		logic [31:0] pos;
		logic [15:0] pos_hold;
		logic [31:0] vel;
		logic [15:0] vel_hold;
		qps_hm_t     hm;
		logic [31:0] cap;
		logic        cap_stb;
		logic [15:0] rdata;
	} qps_state_t;

endpackage

/* sim/qps_core_checker.sv */
// Port checker for the quadrature position block.
// Assumes it is bound to qps_core and sees only that module's ports.
`timescale 1ns/10ps
module qps_core_checker (
	// Clock and reset.
	input wire logic        mclk,
	input wire logic        sys_rst,
	// Register port.
	input wire logic [3:0]  reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic        reg_wr,
	input wire logic        reg_rd,
	input wire logic [15:0] reg_rdata,
	// Encoder pins and results.
	input wire logic        phase_a,
	input wire logic        phase_b,
	input wire logic        index_input,
	input wire logic        home_input,
	input wire logic        capture_strobe,
	input wire logic        irq
);
	default clocking @(posedge mclk); endclocking
	default disable iff (sys_rst);
	// Cycles since a pin moved; a pin event lands three cycles later.
	logic [2:0] calm_q;
	// Saturating count, so a write after a calm spell cannot race a step.
	always_ff @(posedge mclk) begin
		if (sys_rst || $changed({phase_a, phase_b, index_input, home_input}))
			calm_q <= 3'h0;
		else if (calm_q != 3'h7)
			calm_q <= calm_q + 3'h1;
	end
	property p_rst_zero;
		$fell(sys_rst) |-> !irq && !capture_strobe && reg_rdata == 16'h0000;
	endproperty
	a_rst_zero: assert property (p_rst_zero)
		else $error("outputs not zero after reset");
	property p_cap_one;
		capture_strobe |=> !capture_strobe;
	endproperty
	a_cap_one: assert property (p_cap_one)
		else $error("capture strobe longer than one cycle");
	property p_cap_home;
		capture_strobe |-> $past(home_input, 3);
	endproperty
	a_cap_home: assert property (p_cap_home)
		else $error("capture without a home edge");
	property p_hcap_rw;
		reg_wr && reg_addr == qps_pkg::A_HCAP
		##1 reg_rd && reg_addr == qps_pkg::A_HCAP
		|=> reg_rdata == ($past(reg_wdata, 2) & 16'h0001);
	endproperty
	a_hcap_rw: assert property (p_hcap_rw)
		else $error("capture control read back wrong");
	property p_en_rw;
		reg_wr && reg_addr == qps_pkg::A_STAT
		##1 reg_rd && reg_addr == qps_pkg::A_STAT
		|=> (reg_rdata & qps_pkg::M_EN)
			== ($past(reg_wdata, 2) & qps_pkg::M_EN);
	endproperty
	a_en_rw: assert property (p_en_rw)
		else $error("interrupt enables read back wrong");
	property p_irq_off;
		reg_wr && reg_addr == qps_pkg::A_STAT
		&& (reg_wdata & qps_pkg::M_EN) == 16'h0000 |=> !irq;
	endproperty
	a_irq_off: assert property (p_irq_off)
		else $error("interrupt with all enables clear");
	property p_pos_low;
		calm_q >= 3'h4 && reg_wr && reg_addr == qps_pkg::A_POSL
		##1 reg_rd && reg_addr == qps_pkg::A_POSL
		|=> reg_rdata == $past(reg_wdata, 2);
	endproperty
	a_pos_low: assert property (p_pos_low)
		else $error("position low word lost");
	property p_pos_hold;
		calm_q >= 3'h4 && reg_wr && reg_addr == qps_pkg::A_POSHD
		##1 reg_wr && reg_addr == qps_pkg::A_POSL
		##1 reg_rd && reg_addr == qps_pkg::A_POSH
		|=> reg_rdata == $past(reg_wdata, 3);
	endproperty
	a_pos_hold: assert property (p_pos_hold)
		else $error("hold not moved into high word");
	property p_vel_low;
		calm_q >= 3'h4 && reg_wr && reg_addr == qps_pkg::A_VELL
		##1 reg_rd && reg_addr == qps_pkg::A_VELL
		|=> reg_rdata == $past(reg_wdata, 2);
	endproperty
	a_vel_low: assert property (p_vel_low)
		else $error("velocity low word lost");
endmodule
bind qps_core qps_core_checker u_chk (.mclk, .sys_rst, .reg_addr,
	.reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .phase_a, .phase_b,
	.index_input, .home_input, .capture_strobe, .irq);

/* sim/qps_enc_model.sv */
// Encoder model: quadrature phases, index and home pulses.
// Assumes the bench calls its tasks; pins move just after mclk rises.
`timescale 1ns/10ps
module qps_enc_model (
	// Clock.
	input  wire logic mclk,
	// Encoder pins.
	output logic      phase_a,
	output logic      phase_b,
	output logic      index_input,
	output logic      home_input
);
	// Gray position; only one phase moves per step.
	logic [1:0] g = 2'h0;
	// Pins idle low.
	initial begin
		{phase_a, phase_b, index_input, home_input} = 4'h0;
	end
	// Steps n times, gap cycles apart; gap one is the fastest rate.
	task automatic move(input int n, input bit up, input int gap);
		repeat (n) begin
			repeat (gap) @(posedge mclk);
			g = up ? g + 2'h1 : g - 2'h1;
			phase_a <= g[1];
			phase_b <= g[1] ^ g[0];
		end
	endtask
	// Pulse of four cycles on home or index.
	task automatic pulse(input bit home);
		@(posedge mclk);
		if (home) begin
			home_input <= 1'b1;
		end else begin
			index_input <= 1'b1;
		end
		repeat (4) @(posedge mclk);
		home_input <= 1'b0;
		index_input <= 1'b0;
	endtask
endmodule

/* sim/quadrature_position_event_status_test.sv */
// Bench for the quadrature position block.
// Assumes qps_core, its checker and the encoder model are compiled first.
`timescale 1ns/10ps
module quadrature_position_event_status_test;
	logic        mclk;
	logic        sys_rst;
	logic [3:0]  reg_addr;
	logic [15:0] reg_wdata;
	logic        reg_wr;
	logic        reg_rd;
	logic [15:0] reg_rdata;
	logic        pa, pb, idx, home, cstb, irq;
	logic [2:0]  mode;
	logic        legacy;
	logic [31:0] upper, lower, ival, cval, got;
	bit          seen;
	int          bad_count = 0;
	int          num_checks = 0;
	qps_enc_model u_enc (.mclk(mclk), .phase_a(pa), .phase_b(pb),
		.index_input(idx), .home_input(home));
	qps_core u_dut (.mclk(mclk), .sys_rst(sys_rst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .phase_a(pa), .phase_b(pb),
		.index_input(idx), .home_input(home), .position_init_mode(mode),
		.legacy_home_capture_enable(legacy), .upper_compare_value(upper),
		.lower_compare_value(lower), .init_value(ival),
		.capture_value(cval), .capture_strobe(cstb), .irq(irq));
	initial begin
		mclk = 1'b0;
		forever #2.5 mclk = ~mclk;
	end
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		num_checks++;
		if (g !== e) begin
			bad_count++;
			$display("[FAIL] %0t got %h want %h", $time, g, e);
		end
	endtask
	task automatic bus(input bit w, input logic [3:0] a, input logic [15:0] d);
		@(posedge mclk);
		reg_wr <= w;
		reg_rd <= !w;
		reg_addr <= a;
		reg_wdata <= d;
	endtask
	task automatic idle();
		@(posedge mclk);
		reg_wr <= 1'b0;
		reg_rd <= 1'b0;
	endtask
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		bus(1'b1, a, d);
	endtask
	// Read data stand only in the cycle after the strobe.
	task automatic rd(input logic [3:0] a, input logic [15:0] e);
		bus(1'b0, a, 16'h0000);
		idle();
		#1 chk({16'h0000, reg_rdata}, {16'h0000, e});
	endtask
	task automatic settle();
		repeat (8) @(posedge mclk);
	endtask
	// Home pulse while watching for the capture strobe.
	task automatic home_cap();
		seen = 1'b0;
		fork
			u_enc.pulse(1'b1);
			repeat (12) begin
				@(posedge mclk);
				#1 if (cstb === 1'b1) begin
					seen = 1'b1;
					got = cval;
				end
			end
		join
	endtask
	task automatic conclude();
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic t_reset();
		for (int i = 0; i < 10; i++) rd(4'(i), 16'h0000);
		chk({31'h0, irq}, 32'h0);
	endtask
	task automatic t_count();
		u_enc.move(5, 1'b1, 1);
		u_enc.move(2, 1'b0, 4);
		settle();
		rd(qps_pkg::A_POSL, 16'h0003);
		rd(qps_pkg::A_VELL, 16'h0003);
		wr(qps_pkg::A_POSHD, 16'h1234);
		wr(qps_pkg::A_POSL, 16'h5678);
		rd(qps_pkg::A_POSH, 16'h1234);
		wr(qps_pkg::A_POSL, 16'h5678);
		rd(qps_pkg::A_POSL, 16'h5678);
		rd(qps_pkg::A_POSHD, 16'h1234);
		wr(qps_pkg::A_VELHD, 16'habcd);
		wr(qps_pkg::A_VELL, 16'h0001);
		rd(qps_pkg::A_VELL, 16'h0001);
		rd(qps_pkg::A_VELH, 16'habcd);
		// Direct high word writes, then position restored for capture.
		wr(qps_pkg::A_VELH, 16'h0055);
		rd(qps_pkg::A_VELH, 16'h0055);
		wr(qps_pkg::A_POSH, 16'h0077);
		rd(qps_pkg::A_POSH, 16'h0077);
		wr(qps_pkg::A_POSH, 16'h1234);
		rd(qps_pkg::A_POSL, 16'h5678);
	endtask
	task automatic t_capture();
		wr(qps_pkg::A_HCAP, 16'hffff);
		rd(qps_pkg::A_HCAP, 16'h0001);
		home_cap();
		chk({31'h0, seen}, 32'h1);
		chk(got, 32'h1234_5678);
		rd(qps_pkg::A_STAT, 16'h0008);
		wr(qps_pkg::A_HCAP, 16'h0000);
		idle();
		home_cap();
		chk({31'h0, seen}, 32'h0);
		// older enable only with capture control clear.
		@(posedge mclk);
		legacy <= 1'b1;
		home_cap();
		chk({31'h0, seen}, 32'h1);
		chk(got, 32'h1234_5678);
		@(posedge mclk);
		legacy <= 1'b0;
	endtask
	task automatic t_wrap();
		wr(qps_pkg::A_STAT, 16'h0000);
		wr(qps_pkg::A_POSHD, 16'hffff);
		wr(qps_pkg::A_POSL, 16'hffff);
		wr(qps_pkg::A_VELHD, 16'hffff);
		wr(qps_pkg::A_VELL, 16'hffff);
		idle();
		u_enc.move(1, 1'b1, 1);
		settle();
		rd(qps_pkg::A_STAT, 16'h0220);
	endtask
	task automatic t_compare();
		@(posedge mclk);
		upper <= 32'h0000_0003;
		lower <= 32'h0000_0001;
		wr(qps_pkg::A_STAT, 16'h0000);
		idle();
		u_enc.move(4, 1'b1, 1);
		settle();
		rd(qps_pkg::A_STAT, 16'h2800);
		wr(qps_pkg::A_CLR, 16'h2800);
		idle();
		rd(qps_pkg::A_STAT, 16'h2000);
		// Limits change only on a rising edge, like every other input.
		@(posedge mclk);
		upper <= 32'h7fff_ffff;
		lower <= 32'h8000_0000;
	endtask
	task automatic t_irq();
		wr(qps_pkg::A_STAT, 16'h0000);
		idle();
		u_enc.pulse(1'b0);
		settle();
		chk({31'h0, irq}, 32'h0);
		wr(qps_pkg::A_STAT, 16'h0003);
		rd(qps_pkg::A_STAT, 16'h0003);
		chk({31'h0, irq}, 32'h1);
		wr(qps_pkg::A_STAT, 16'h2aa9);
		rd(qps_pkg::A_STAT, 16'h0001);
		chk({31'h0, irq}, 32'h0);
	endtask
	task automatic t_homing();
		for (int m = 3; m < 5; m++) begin
			@(posedge mclk);
			mode <= 3'(m);
			ival <= 32'h0001_2340 + 32'(m);
			wr(qps_pkg::A_STAT, 16'h0000);
			idle();
			u_enc.pulse(1'b1);
			settle();
			repeat (m - 2) begin
				u_enc.pulse(1'b0);
				settle();
			end
			rd(qps_pkg::A_POSL, 16'(16'h2340 + m));
			rd(qps_pkg::A_POSHD, 16'h0001);
			rd(qps_pkg::A_STAT, 16'h008a);
		end
	endtask
	// Watchdog well beyond the few hundred cycles the run needs.
	initial begin
		#100000;
		bad_count++;
		conclude();
	end
	initial begin
		sys_rst = 1'b1;
		{reg_wr, reg_rd, reg_addr, reg_wdata} = 22'h0;
		mode = 3'h0;
		legacy = 1'b0;
		upper = 32'h7fff_ffff;
		lower = 32'h8000_0000;
		ival = 32'h0000_0000;
		repeat (12) @(posedge mclk);
		sys_rst <= 1'b0;
		t_reset();
		t_count();
		t_capture();
		t_wrap();
		t_compare();
		t_irq();
		t_homing();
		conclude();
	end
endmodule

/* src/qps_core.sv */
// Quadrature position, velocity and event status logic with its registers.
// Assumes encoder pins are asynchronous and the register master sits on mclk.
//
// How it works
// RULE1: Home rising edge captures position when enabled.
// RULE2: Home capture register bits 15-1 read zero.
// RULE3: Set at-or-above flag when count >= upper.
// RULE4: Set at-or-below flag when count <= lower.
// RULE5: Set position overflow flag on counter wrap.
// RULE6: Homing done flag in modes 011, 100.
// RULE7: Set speed overflow flag on velocity wrap.
// RULE8: Set home seen flag on home event.
// RULE9: Set index seen flag on index event.
// RULE10: Interrupt only for flags with enable set.
// RULE11: Flags hardware set, software clear only.
// RULE12: Position counter 32 bits, two word registers.
// RULE13: High position word goes through hold register; the code also reads and writes it directly at A_POSH.
// RULE14: Velocity counter 32 bits, two word registers.
// RULE15: All counters, enables, flags reset to zero.
// RULE16: Velocity high word has its own hold.
// RULE17: Software never enables both capture controls.
// RULE18: Low word read/write moves hold atomically.
// RULE19: Write zero clears flag, hardware set wins.
`timescale 1ns/10ps
module qps_core (
	// Clock and reset.
	input  wire logic        mclk,
	input  wire logic        sys_rst,
	// Register port.
	input  wire logic [3:0]  reg_addr,
	input  wire logic [15:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [15:0] reg_rdata,
	// Encoder pins, asynchronous to mclk.
	input  wire logic        phase_a,
	input  wire logic        phase_b,
	input  wire logic        index_input,
	input  wire logic        home_input,
	// Settings from the surrounding encoder logic on mclk.
	input  wire logic [2:0]  position_init_mode,
	input  wire logic        legacy_home_capture_enable,
	input  wire logic [31:0] upper_compare_value,
	input  wire logic [31:0] lower_compare_value,
	input  wire logic [31:0] init_value,
	// Capture result towards the capture register.
	output logic      [31:0] capture_value,
	output logic             capture_strobe,
	// Level interrupt request.
	output logic             irq
);

	// Registered state and its next value.
	qps_pkg::qps_state_t st_q;
	qps_pkg::qps_state_t st_d;

	// Bundled register request.
	qps_pkg::qps_bus_t bus;

	// Decoded pin events, all on synchronized levels.
	logic step;
	logic up;
	logic home_rise;
	logic idx_rise;

	// Raw hardware set requests for each flag.
	logic [15:0] hw_set;

	// Software clear requests for each flag.
	logic [15:0] sw_clr;

	// Position after counting, before any software write.
	logic [31:0] pos_next;
	logic [31:0] vel_next;
	logic        pos_wrap;
	logic        vel_wrap;
	logic        homed;

	// Gather the bus request into one carrier.
	always_comb begin
		bus.addr  = reg_addr;
		bus.wdata = reg_wdata;
		bus.wr    = reg_wr;
		bus.rd    = reg_rd;
	end

	// Pin event decode. Only the second synchronizer stage and the stored
	// previous level are looked at, never the first stage.
	always_comb begin
		step = (st_q.s2.a ^ st_q.prev.a) ^ (st_q.s2.b ^ st_q.prev.b);
		up = st_q.prev.a ^ st_q.s2.b;
		home_rise = st_q.s2.home & ~st_q.prev.home;
		idx_rise = st_q.s2.idx & ~st_q.prev.idx;
	end

	// Counting and homing. A double transition (both phases at once) is
	// an illegal quadrature step and is dropped rather than guessed.
	always_comb begin
		pos_next = st_q.pos;
		vel_next = st_q.vel;
		pos_wrap = 1'b0;
		vel_wrap = 1'b0;
		homed = 1'b0;
		if (step) begin
			if (up) begin
				pos_next = st_q.pos + qps_pkg::ONE32;
				vel_next = st_q.vel + qps_pkg::ONE32;
				// RULE5: wrap upward
				pos_wrap = (st_q.pos == qps_pkg::MAX32);
				// RULE7: wrap upward
				vel_wrap = (st_q.vel == qps_pkg::MAX32);
			end else begin
				pos_next = st_q.pos - qps_pkg::ONE32;
				vel_next = st_q.vel - qps_pkg::ONE32;
				// RULE5: wrap downward
				pos_wrap = (st_q.pos == qps_pkg::R32);
				// RULE7: wrap downward
				vel_wrap = (st_q.vel == qps_pkg::R32);
			end
		end
		// RULE6: index after home reloads
		if (idx_rise) begin
			if (position_init_mode == qps_pkg::PI_FIRST &&
				st_q.hm == qps_pkg::HM_ARMED) begin
				homed = 1'b1;
			end else if (position_init_mode == qps_pkg::PI_SECOND &&
				st_q.hm == qps_pkg::HM_ONE) begin
				homed = 1'b1;
			end
		end
		if (homed) begin
			pos_next = init_value;
		end
	end

	// Hardware flag set requests, placed on the flag bit positions.
	always_comb begin
		hw_set = qps_pkg::R16;
		// RULE3: at or above upper
		hw_set[qps_pkg::B_GE] =
			$signed(pos_next) >= $signed(upper_compare_value);
		// RULE4: at or below lower
		hw_set[qps_pkg::B_LE] =
			$signed(pos_next) <= $signed(lower_compare_value);
		hw_set[qps_pkg::B_POV] = pos_wrap;
		hw_set[qps_pkg::B_HDN] = homed;
		hw_set[qps_pkg::B_VOV] = vel_wrap;
		// RULE8: home edge seen
		hw_set[qps_pkg::B_HOM] = home_rise;
		// RULE9: index edge seen
		hw_set[qps_pkg::B_IDX] = idx_rise;
	end

	// Software clear requests. Writing zero to a flag bit of the status
	// register clears it; the separate clear register clears on a one.
	always_comb begin
		sw_clr = qps_pkg::R16;
		// RULE19: write zero clears
		if (bus.wr && bus.addr == qps_pkg::A_STAT) begin
			sw_clr = ~bus.wdata & qps_pkg::M_FLAG;
		end else if (bus.wr && bus.addr == qps_pkg::A_CLR) begin
			sw_clr = bus.wdata & qps_pkg::M_FLAG;
		end
	end

	// Next-state logic for everything the block remembers.
	always_comb begin
		st_d = st_q;
		st_d.cap_stb = 1'b0;
		// Two-stage synchronizers for the encoder pins.
		st_d.s1.a = phase_a;
		st_d.s1.b = phase_b;
		st_d.s1.idx = index_input;
		st_d.s1.home = home_input;
		st_d.s2 = st_q.s1;
		st_d.prev = st_q.s2;

		// Counters take the counted value unless software writes below.
		st_d.pos = pos_next;
		st_d.vel = vel_next;

		// Homing sequence tracks home then index events.
		case (st_q.hm)
			qps_pkg::HM_IDLE: begin
				if (home_rise) begin
					st_d.hm = qps_pkg::HM_ARMED;
				end
			end
			qps_pkg::HM_ARMED: begin
				if (idx_rise) begin
					st_d.hm = homed ? qps_pkg::HM_IDLE
						: qps_pkg::HM_ONE;
				end
			end
			qps_pkg::HM_ONE: begin
				if (idx_rise) begin
					st_d.hm = qps_pkg::HM_IDLE;
				end
			end
			default: begin
				st_d.hm = qps_pkg::HM_IDLE;
			end
		endcase
		// Outside the homing modes the sequence never stays armed.
		if (position_init_mode != qps_pkg::PI_FIRST &&
			position_init_mode != qps_pkg::PI_SECOND) begin
			st_d.hm = qps_pkg::HM_IDLE;
		end

		// RULE1: capture on home edge
		if (home_rise && (st_q.hcap || legacy_home_capture_enable)) begin
			st_d.cap = st_q.pos;
			st_d.cap_stb = 1'b1;
		end

		// RULE11: set beats clear
		st_d.stat = ((st_q.stat & ~sw_clr) | hw_set) & qps_pkg::M_FLAG
			| (st_q.stat & qps_pkg::M_EN);

		// Register writes.
		if (bus.wr) begin
			case (bus.addr)
				qps_pkg::A_HCAP: begin
					// RULE2: only bit 0 stored
					st_d.hcap = bus.wdata[qps_pkg::B_HCAP];
				end
				qps_pkg::A_STAT: begin
					// RULE10: enables are plain storage
					st_d.stat = (st_d.stat & qps_pkg::M_FLAG)
						| (bus.wdata & qps_pkg::M_EN);
				end
				qps_pkg::A_POSL: begin
					// RULE18: low write loads high from hold
					st_d.pos = {st_q.pos_hold, bus.wdata};
				end
				qps_pkg::A_POSH: begin
					// RULE12: direct high word write
					st_d.pos = {bus.wdata, st_q.pos[15:0]};
				end
				qps_pkg::A_POSHD: begin
					// RULE13: hold register write
					st_d.pos_hold = bus.wdata;
				end
				qps_pkg::A_VELL: begin
					// RULE16: low write loads high from hold
					st_d.vel = {st_q.vel_hold, bus.wdata};
				end
				qps_pkg::A_VELH: begin
					// RULE14: direct high word write
					st_d.vel = {bus.wdata, st_q.vel[15:0]};
				end
				qps_pkg::A_VELHD: begin
					st_d.vel_hold = bus.wdata;
				end
				default: begin
					// Unmapped and clear-register writes store nothing.
					st_d.hcap = st_q.hcap;
				end
			endcase
		end

		// Register reads answer one cycle later from a flip-flop.
		st_d.rdata = qps_pkg::R16;
		if (bus.rd) begin
			case (bus.addr)
				qps_pkg::A_HCAP: begin
					// RULE2: upper bits read zero
					st_d.rdata = {15'h0000, st_q.hcap};
				end
				qps_pkg::A_STAT: begin
					st_d.rdata = st_q.stat;
				end
				qps_pkg::A_POSL: begin
					// RULE18: low read latches high word
					st_d.rdata = st_q.pos[15:0];
					st_d.pos_hold = st_q.pos[31:16];
				end
				qps_pkg::A_POSH: begin
					st_d.rdata = st_q.pos[31:16];
				end
				qps_pkg::A_POSHD: begin
					st_d.rdata = st_q.pos_hold;
				end
				qps_pkg::A_VELL: begin
					// RULE16: low read latches high word
					st_d.rdata = st_q.vel[15:0];
					st_d.vel_hold = st_q.vel[31:16];
				end
				qps_pkg::A_VELH: begin
					st_d.rdata = st_q.vel[31:16];
				end
				qps_pkg::A_VELHD: begin
					st_d.rdata = st_q.vel_hold;
				end
				default: begin
					// Unmapped and write-only registers read zero.
					st_d.rdata = qps_pkg::R16;
				end
			endcase
		end
	end

	// State register. Reset gives every field a constant.
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			// RULE15: zero at reset
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	// Outputs. Data outputs come straight from flip-flops.
	always_comb begin
		reg_rdata = st_q.rdata;
		capture_value = st_q.cap;
		capture_strobe = st_q.cap_stb;
		// RULE10: enabled flags only
		irq = |(st_q.stat & {1'b0, st_q.stat[15:1]} & qps_pkg::M_EN
			| (st_q.stat & qps_pkg::M_FLAG & {st_q.stat[14:0], 1'b0}));
	end

endmodule
